/* File: acr_readout.v */
// Conversion control and external-clock serial readout with marker and chain
// Operation
// - External mode: read/convert and select control reading
// - Shift previous result, valid falling then rising
// - Clock edge outside read arms marker
// - Marker then bits; 17 or 18 pulses
// - Idle clock: first rising edge gives MSB
// - Chain input passes through after own word
// - After word, hold chain level from start
// - Result shifted most significant bit first
// - Format select picks straight or two's complement
// - Conversion starts when second control falls
// - Busy low during conversion, high on store
module acr_readout (
	// Clock and reset
	input wire core_clk,
	input wire nrst,
	// Control pins (asynchronous)
	input wire ext_clock_select,
	input wire chip_select_n,
	input wire read_convert,
	input wire output_format_select,
	// Serial link pins (asynchronous)
	input wire serial_shift_clock,
	input wire chain_in,
	// Conversion core side
	input wire [15:0] conv_result,
	// Outputs
	output reg serial_data_q,
	output reg marker_q,
	output reg busy_q,
	output reg reading_q
);
`include "acr_defs.vh"

	// Synchroniser pairs and previous samples for edge detection
	reg [1:0] cs_s_q, rc_s_q, sck_s_q, tag_s_q, ext_s_q, fmt_s_q;
	reg cs_p_q, rc_p_q, sck_p_q;
	// Conversion down-counter
	reg [11:0] conv_cnt_q;
	// Read state: marker arming, bit count, shift and null level
	reg armed_q;
	reg marker_phase_q;
	reg [`ACR_CNT_W-1:0] bit_cnt_q;
	reg [15:0] shift_q;
	reg chain_hold_q;
	// Stored result and synchronised pin levels
	wire [15:0] stored;
	wire cs_n, rc, sck, tag, ext, fmt;
	wire sck_rise, conv_start, read_start, read_end, conv_done;

	// Two-stage synchronisers; only the second stage feeds logic
	always @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			cs_s_q <= 2'h3;
			rc_s_q <= 2'h3;
			sck_s_q <= 2'h0;
			tag_s_q <= 2'h0;
			ext_s_q <= 2'h0;
			fmt_s_q <= 2'h3;
		end
		else
		begin
			cs_s_q <= {cs_s_q[0], chip_select_n};
			rc_s_q <= {rc_s_q[0], read_convert};
			sck_s_q <= {sck_s_q[0], serial_shift_clock};
			tag_s_q <= {tag_s_q[0], chain_in};
			ext_s_q <= {ext_s_q[0], ext_clock_select};
			fmt_s_q <= {fmt_s_q[0], output_format_select};
		end
	end

	assign cs_n = cs_s_q[1];
	assign rc = rc_s_q[1];
	assign sck = sck_s_q[1];
	assign tag = tag_s_q[1];
	assign ext = ext_s_q[1];
	assign fmt = fmt_s_q[1];

	// Previous-sample registers for edge detection
	always @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			cs_p_q <= 1'b1;
			rc_p_q <= 1'b1;
			sck_p_q <= 1'b0;
		end
		else
		begin
			cs_p_q <= cs_n;
			rc_p_q <= rc;
			sck_p_q <= sck;
		end
	end

	assign sck_rise = sck & ~sck_p_q;
	// Start on the falling edge of the later of the two controls
	assign conv_start = busy_q & ~cs_n & ~rc & ~(cs_p_q == 1'b0 && rc_p_q == 1'b0);
	// Read state entry on read/convert rise or select fall
	assign read_start = ext & ~reading_q & ((rc & ~rc_p_q & ~cs_n) |
		(~cs_n & cs_p_q & rc));
	// Leaving read state when select rises or read/convert falls
	assign read_end = reading_q & (cs_n | ~rc | ~ext);
	// Last busy-low cycle; the store and the busy rise share this edge
	assign conv_done = ~busy_q && conv_cnt_q == 12'h001;

	// Format conversion: straight binary flips the sign bit
	function [15:0] acr_fmt;
		input [15:0] raw;
		input straight;
		begin
			acr_fmt = (straight == `ACR_FMT_STRAIGHT) ? (raw ^ `ACR_MSB_FLIP) : raw;
		end
	endfunction

	// Result register written when conversion completes
	acr_result_reg u_result (
		.core_clk(core_clk),
		.nrst(nrst),
		.wr_en(conv_done),
		.wr_data(conv_result),
		.rd_data(stored)
	);

	// Conversion timer; busy low for the conversion time
	always @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			busy_q <= 1'b1;
			conv_cnt_q <= 12'h000;
		end
		else if (conv_start)
		begin
			busy_q <= 1'b0;
			conv_cnt_q <= `ACR_CONV_CYC;
		end
		else if (conv_done)
		begin
			busy_q <= 1'b1;
			conv_cnt_q <= 12'h000;
		end
		else if (!busy_q)
			conv_cnt_q <= conv_cnt_q - 12'h001;
	end

	// Read state, marker arming and shifting on shift clock edges.
	// One shift register serves both the own word and the chain: each data
	// edge moves a chain-input sample in at the bottom, so after the own word
	// and the null bit the upstream bits follow in order with no extra store.
	always @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			reading_q <= 1'b0;
			armed_q <= 1'b0;
			marker_phase_q <= 1'b0;
			bit_cnt_q <= {`ACR_CNT_W{1'b0}};
			shift_q <= 16'h0000;
			chain_hold_q <= 1'b0;
			serial_data_q <= 1'b0;
			marker_q <= 1'b0;
		end
		else if (read_start)
		begin
			reading_q <= 1'b1;
			// An edge in the entry cycle still lies outside the read, so it arms
			marker_phase_q <= armed_q | sck_rise;
			armed_q <= 1'b0;
			bit_cnt_q <= {`ACR_CNT_W{1'b0}};
			shift_q <= acr_fmt(stored, fmt);
			chain_hold_q <= tag;
		end
		else if (!reading_q || read_end)
		begin
			// Idle: any rising edge seen here while not reading arms the marker for the next read
			reading_q <= 1'b0;
			marker_q <= 1'b0;
			if (sck_rise && !reading_q)
				armed_q <= 1'b1;
		end
		else if (sck_rise)
		begin
			if (marker_phase_q)
			begin
				// Marker edge: data output keeps its value, nothing shifts
				marker_q <= 1'b1;
				marker_phase_q <= 1'b0;
			end
			else if (bit_cnt_q < `ACR_WORD_BITS)
			begin
				// Own word, MSB first, chain samples fill from the bottom
				marker_q <= 1'b0;
				serial_data_q <= shift_q[15];
				shift_q <= {shift_q[14:0], tag};
				bit_cnt_q <= bit_cnt_q + `ACR_CNT_ONE;
			end
			else if (bit_cnt_q == `ACR_WORD_BITS)
			begin
				// Null bit is the chain level seen at read entry; the oldest
				// chain sample is dropped, being that same idle level
				serial_data_q <= chain_hold_q;
				shift_q <= {shift_q[14:0], tag};
				bit_cnt_q <= bit_cnt_q + `ACR_CNT_ONE;
			end
			else
			begin
				// Pass-through: chain input delayed by one word plus null bit
				serial_data_q <= shift_q[15];
				shift_q <= {shift_q[14:0], tag};
			end
		end
	end
endmodule // acr_readout

/* File: acr_defs.vh */
// Shared constants for the external-clock serial readout block
`ifndef ACR_DEFS_VH
`define ACR_DEFS_VH
`define ACR_WORD_BITS 5'h10
`define ACR_CNT_W 5
`define ACR_CNT_ONE 5'h01
`define ACR_CLK_NS 5
`define ACR_CONV_NS 2200
// Conversion time in core cycles: 2200 ns at 5 ns a cycle
`define ACR_CONV_CYC 12'h1B8
`define ACR_SHCLK_MAX_KHZ 28500
`define ACR_RESULT_RST 16'h0000
`define ACR_MSB_FLIP 16'h8000
`define ACR_FMT_STRAIGHT 1'b1
`endif

/* File: acr_result_reg.v */
// Output register holding the last completed conversion result
module acr_result_reg (
	// Clock and reset
	input wire core_clk,
	input wire nrst,
	// Write side
	input wire wr_en,
	input wire [15:0] wr_data,
	// Read side
	output reg [15:0] rd_data
);
`include "acr_defs.vh"

	// Result is stored only when conversion finishes
	always @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			rd_data <= `ACR_RESULT_RST;
		else if (wr_en)
			rd_data <= wr_data;
	end
endmodule // acr_result_reg

/* File: acr_readout_chk.sv */
// Checker on the serial readout pins
module acr_readout_chk (
	// Clock and reset
	input wire core_clk,
	input wire nrst,
	// Control and link pins
	input wire ext_clock_select,
	input wire chip_select_n,
	input wire read_convert,
	input wire serial_shift_clock,
	// Outputs
	input wire serial_data_q,
	input wire marker_q,
	input wire busy_q,
	input wire reading_q
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [9:0] lo_q;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	// Busy-low span, counted so conversion time is checked by figure
	always_ff @(posedge core_clk or negedge nrst)
		if (!nrst)
			lo_q <= 10'h000;
		else
			lo_q <= busy_q ? 10'h000 : lo_q + 10'h001;
	cnv_start_a: assert property ($fell(busy_q) |-> !chip_select_n && !read_convert)
		else $error("start");
	cnv_len_a: assert property ($rose(busy_q) |-> lo_q inside {[10'h1AE:10'h1C2]})
		else $error("length");
	cnv_hold_a: assert property (!busy_q && lo_q < 10'h1AE |=> !busy_q)
		else $error("early");
	ext_only_a: assert property ($rose(reading_q) |-> ext_clock_select)
		else $error("mode");
	rd_entry_a: assert property ($rose(reading_q) |-> read_convert && !chip_select_n)
		else $error("entry");
	mk_read_a: assert property (marker_q |-> reading_q)
		else $error("marker");
	mk_edge_a: assert property ($rose(marker_q) |-> serial_shift_clock)
		else $error("edge");
	dat_edge_a: assert property (reading_q && $past(reading_q) && $changed(serial_data_q)
		|-> serial_shift_clock)
		else $error("data");
	// Main scenarios reached
	cover property ($rose(marker_q));
	cover property ($rose(reading_q));
	cover property ($rose(busy_q));
endmodule // acr_readout_chk

bind acr_readout acr_readout_chk chk_u (.*);

/* File: acr_host.sv */
// Host port model: gated shift clock, capture on falling edges
module acr_host (
	// Link pins
	output logic serial_shift_clock,
	input wire serial_data_q,
	input wire marker_q
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [17:0] word, flag;
	// Shift clock idles low between reads
	initial serial_shift_clock = 1'b0;
	// Clock runs only while shift is called, inside or outside a read; 125 ns keeps well under the rate limit
	task automatic shift(int n);
		word = 18'h0_0000;
		flag = 18'h0_0000;
		repeat (n)
		begin
			#62.5 serial_shift_clock = 1'b1;
			#62.5 serial_shift_clock = 1'b0;
			word = {word[16:0], serial_data_q};
			flag = {flag[16:0], marker_q};
		end
	endtask
endmodule // acr_host

/* File: tb_acr_readout.sv */
// Self-checking bench for the serial readout
module tb_acr_readout;
	timeunit 1ns;
	timeprecision 100ps;
	logic core_clk = 1'b0, nrst = 1'b0, ext_clock_select = 1'b1;
	logic chip_select_n = 1'b1, read_convert = 1'b1, chain_in = 1'b1;
	logic output_format_select = 1'b1;
	logic [15:0] conv_result = 16'h0000;
	wire serial_shift_clock, serial_data_q, marker_q, busy_q, reading_q;
	int error_cnt = 0, checks = 0;
	acr_readout dut_u (.*);
	acr_host host_u (.*);
	always #2.5 core_clk = ~core_clk;
	// Compare and count
	task automatic chk(string nm, logic [17:0] exp, logic [17:0] got);
		checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[FAIL] %s exp %h got %h", nm, exp, got);
		end
	endtask
	task automatic tick(int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	// Select falls second to convert; waits out busy, bounded
	task automatic convert(logic [15:0] raw);
		conv_result = raw;
		read_convert = 1'b0;
		tick(4);
		chip_select_n = 1'b0;
		tick(8);
		chk("busy_lo", 18'h0_0000, {17'h0_0000, busy_q});
		for (int i = 0; i < 999 && busy_q !== 1'b1; i++) tick(1);
		chk("busy_hi", 18'h0_0001, {17'h0_0000, busy_q});
	endtask
	// Idle clock, select falls with read high, straight binary
	task automatic read_plain();
		convert(16'h1234);
		chip_select_n = 1'b1;
		tick(4);
		read_convert = 1'b1;
		tick(4);
		chip_select_n = 1'b0;
		tick(4);
		chk("reading", 18'h0_0001, {17'h0_0000, reading_q});
		host_u.shift(17);
		chk("plain", 18'h1_2469, host_u.word);
		chk("nomark", 18'h0_0000, host_u.flag);
		tick(1);
		chip_select_n = 1'b1;
	endtask
	// Edge outside read arms marker; read high with select low, raw code
	task automatic read_marked();
		output_format_select = 1'b0;
		chain_in = 1'b0;
		tick(8);
		host_u.shift(1);
		tick(1);
		convert(16'h8001);
		read_convert = 1'b1;
		tick(4);
		host_u.shift(18);
		chk("marked", 18'h1_0002, {1'b0, host_u.word[16:0]});
		chk("mark", 18'h2_0000, host_u.flag);
	endtask
	// Mode off refuses entry; then a chain read with an upstream word behind
	task automatic read_chain();
		logic [16:0] up;
		up = {16'hA5C3, 1'b0};
		chip_select_n = 1'b1;
		ext_clock_select = 1'b0;
		chain_in = 1'b1;
		tick(4);
		chip_select_n = 1'b0;
		tick(4);
		chk("noext", 18'h0_0000, {17'h0_0000, reading_q});
		chip_select_n = 1'b1;
		ext_clock_select = 1'b1;
		tick(4);
		chip_select_n = 1'b0;
		tick(4);
		fork
			host_u.shift(34);
			// Upstream device: its next bit settles well after each rising edge
			repeat (17)
			begin
				@(posedge serial_shift_clock);
				tick(2);
				chain_in = up[16];
				up = {up[15:0], 1'b0};
			end
		join
		chk("chain", 18'h3_4B86, host_u.word);
		chk("chainmark", 18'h0_0000, host_u.flag);
		chip_select_n = 1'b1;
	endtask
	initial
	begin
		tick(20);
		nrst = 1'b1;
		tick(4);
		read_plain();
		read_marked();
		read_chain();
		results();
	end
	// Watchdog
	initial
	begin
		#40000;
		error_cnt++;
		results();
	end
	task automatic results();
		if (error_cnt == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
endmodule // tb_acr_readout
